// *** design/radio_rx_sync_tx_config_bank.sv ***
// Implementation choice: the APB slave port.
`include "radio_cfg_defs.svh"

module radio_rx_sync_tx_config_bank #(
  parameter int CHIP_DIV = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  rssi_in,
  input  wire logic        tx_start,
  output logic             tx_bit,
  output logic             tx_bit_valid,
  output logic             tx_busy,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_valid,
  output logic             pattern_found,
  output logic             ref_clk_tick,
  output logic             peak_update,
  output logic [2:0]       peak_level_reduction,
  output logic [1:0]       average_filter_coeff_select,
  output logic [3:0]       tx_antialias_cutoff,
  output logic [2:0]       tx_power
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]                 ref_div_q;
  radio_cfg_pkg::onoff_cfg_t  onoff_q;
  logic [7:0]                 pat_q [4];
  radio_cfg_pkg::tx_cfg_t     txfp_q;
  logic [7:0]                 pat_ctrl_q;
  logic [7:0]                 rssi_q;
  logic                       found_q;
  logic [9:0]                 idx;
  logic                       wr_en;
  logic                       mapped;
  logic                       recog_en;
  logic [1:0]                 pattern_size;
  logic [1:0]                 tol;

  assign idx      = paddr[11:2];
  assign wr_en    = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign recog_en = pat_ctrl_q[`F_RECOG_BIT];
  assign pattern_size = pat_ctrl_q[`F_SIZE_LSB +: 2];
  assign tol      = pat_ctrl_q[`F_TOL_LSB +: 2];

  always_comb begin
    mapped = 1'b1;
    unique case (idx)
      {2'b00, `IDX_REF_DIV}, {2'b00, `IDX_RSSI}, {2'b00, `IDX_ONOFF},
      {2'b00, `IDX_PAT3}, {2'b00, `IDX_PAT2}, {2'b00, `IDX_PAT1},
      {2'b00, `IDX_PAT0}, {2'b00, `IDX_TXFP}, {2'b00, `IDX_PAT_CTRL},
      {2'b00, `IDX_PAT_STAT}: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped access answers with an error, no side effect
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_q  <= `RST_REF_DIV;
      onoff_q    <= `RST_ONOFF;
      pat_q[0]   <= `RST_PAT;
      pat_q[1]   <= `RST_PAT;
      pat_q[2]   <= `RST_PAT;
      pat_q[3]   <= `RST_PAT;
      txfp_q     <= `RST_TXFP;
      pat_ctrl_q <= `RST_PAT_CTRL;
    end else if (wr_en) begin
      unique case (idx)
        {2'b00, `IDX_REF_DIV}:  ref_div_q  <= pwdata[7:0];
        {2'b00, `IDX_ONOFF}:    onoff_q    <= pwdata[7:0];
        {2'b00, `IDX_PAT3}:     pat_q[3]   <= pwdata[7:0];
        {2'b00, `IDX_PAT2}:     pat_q[2]   <= pwdata[7:0];
        {2'b00, `IDX_PAT1}:     pat_q[1]   <= pwdata[7:0];
        {2'b00, `IDX_PAT0}:     pat_q[0]   <= pwdata[7:0];
        {2'b00, `IDX_TXFP}:     txfp_q     <= {pwdata[7:1], 1'b0};
        {2'b00, `IDX_PAT_CTRL}: pat_ctrl_q <= {1'b0, 1'b0, pwdata[5:1], 1'b0};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (idx)
      {2'b00, `IDX_REF_DIV}:  prdata[7:0] = ref_div_q;
      {2'b00, `IDX_RSSI}:     prdata[7:0] = rssi_q;
      {2'b00, `IDX_ONOFF}:    prdata[7:0] = onoff_q;
      {2'b00, `IDX_PAT3}:     prdata[7:0] = pat_q[3];
      {2'b00, `IDX_PAT2}:     prdata[7:0] = pat_q[2];
      {2'b00, `IDX_PAT1}:     prdata[7:0] = pat_q[1];
      {2'b00, `IDX_PAT0}:     prdata[7:0] = pat_q[0];
      {2'b00, `IDX_TXFP}:     prdata[7:0] = txfp_q;
      {2'b00, `IDX_PAT_CTRL}: prdata[7:0] = pat_ctrl_q;
      {2'b00, `IDX_PAT_STAT}: prdata[0]   = found_q;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Strength sampling (pin input, three stages)
  // ----------------------------------------------------------------
  logic [7:0] rs1_q;
  logic [7:0] rs2_q;
  logic [7:0] rs3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs1_q  <= 8'h00;
      rs2_q  <= 8'h00;
      rs3_q  <= 8'h00;
      rssi_q <= 8'h00;
    end else begin
      rs1_q <= rssi_in;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
      // Only take a value once two stages agree
      if (rs2_q == rs3_q) begin
        rssi_q <= rs3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference divider and peak update strobes
  // ----------------------------------------------------------------
  logic [7:0]  ref_cnt_q;
  logic [11:0] chip_cnt_q;
  logic [11:0] upd_period;

  // tick every divider plus one cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q    <= 8'h00;
      ref_clk_tick <= 1'b0;
    end else if (ref_cnt_q >= ref_div_q) begin
      ref_cnt_q    <= 8'h00;
      ref_clk_tick <= 1'b1;
    end else begin
      ref_cnt_q    <= ref_cnt_q + 8'h01;
      ref_clk_tick <= 1'b0;
    end
  end

  // period in reference ticks per code
  always_comb begin
    logic [2:0] c;
    c = onoff_q.peak_update_period;
    if (!c[2]) begin
      upd_period = 12'(CHIP_DIV) << c[1:0];
    end else begin
      upd_period = 12'(CHIP_DIV) >> ({1'b0, c[1:0]} + 3'h1);
    end
    if (upd_period == 12'h000) begin
      upd_period = 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_cnt_q  <= 12'h000;
      peak_update <= 1'b0;
    end else begin
      peak_update <= 1'b0;
      if (ref_clk_tick) begin
        if (chip_cnt_q + 12'h001 >= upd_period) begin
          chip_cnt_q  <= 12'h000;
          peak_update <= 1'b1;
        end else begin
          chip_cnt_q <= chip_cnt_q + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peak_level_reduction        <= 3'h0;
      average_filter_coeff_select <= 2'h0;
      tx_antialias_cutoff         <= 4'h7;
      tx_power                    <= 3'h0;
    end else begin
      peak_level_reduction        <= onoff_q.peak_level_reduction;
      average_filter_coeff_select <= onoff_q.average_filter_coeff_select;
      tx_antialias_cutoff         <= txfp_q.tx_antialias_cutoff;
      // unused codes held at the maximum power code
      tx_power <= (txfp_q.tx_power > `POUT_MAX_CODE) ? `POUT_MAX_CODE
                                                      : txfp_q.tx_power;
    end
  end

  // ----------------------------------------------------------------
  // Pattern transmit
  // ----------------------------------------------------------------
  radio_cfg_pkg::tx_state_t st_q;
  logic [4:0]               tx_cnt_q;
  logic [31:0]              tx_pat;
  logic [4:0]               tx_last;

  assign tx_pat  = {pat_q[3], pat_q[2], pat_q[1], pat_q[0]};
  assign tx_last = 5'({pattern_size, 3'b111});
  assign tx_busy = (st_q == radio_cfg_pkg::ST_SEND);

  // msb byte first, bytes by size
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= radio_cfg_pkg::ST_IDLE;
      tx_cnt_q     <= 5'h00;
      tx_bit       <= 1'b0;
      tx_bit_valid <= 1'b0;
    end else begin
      tx_bit_valid <= 1'b0;
      unique case (st_q)
        radio_cfg_pkg::ST_IDLE: begin
          if (tx_start) begin
            st_q     <= radio_cfg_pkg::ST_SEND;
            tx_cnt_q <= 5'h00;
          end
        end
        radio_cfg_pkg::ST_SEND: begin
          if (ref_clk_tick) begin
            tx_bit       <= tx_pat[5'd31 - tx_cnt_q];
            tx_bit_valid <= 1'b1;
            tx_cnt_q     <= tx_cnt_q + 5'h01;
            if (tx_cnt_q == tx_last) begin
              st_q <= radio_cfg_pkg::ST_IDLE;
            end
          end
        end
        default: st_q <= radio_cfg_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pattern detect
  // ----------------------------------------------------------------
  logic [31:0] rx_sh_q;
  logic [31:0] cmp_mask;
  logic [31:0] diff;
  logic [5:0]  err_cnt;
  logic [5:0]  pat_shift;

  assign pat_shift = 6'd24 - {1'b0, pattern_size, 3'b000};
  // Window keeps only the newest bits, one byte per size step
  assign cmp_mask  = 32'hffff_ffff >> pat_shift;
  // oldest bit meets first sent bit
  assign diff      = ({rx_sh_q[30:0], rx_bit} ^ (tx_pat >> pat_shift)) & cmp_mask;

  always_comb begin
    err_cnt = 6'h00;
    for (int i = 0; i < 32; i++) begin
      err_cnt = err_cnt + {5'h00, diff[i]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q <= 32'h0000_0000;
    end else if (rx_bit_valid && recog_en) begin
      rx_sh_q <= {rx_sh_q[30:0], rx_bit};
    end
  end

  // accept within tolerance; sticky, a one written to bit 0 clears, a hit in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      found_q       <= 1'b0;
      pattern_found <= 1'b0;
    end else begin
      pattern_found <= rx_bit_valid && recog_en && (err_cnt <= {4'h0, tol});
      if (rx_bit_valid && recog_en && (err_cnt <= {4'h0, tol})) begin
        found_q <= 1'b1;
      end else if (wr_en && idx == {2'b00, `IDX_PAT_STAT} && pwdata[0]) begin
        found_q <= 1'b0;
      end
    end
  end

endmodule : radio_rx_sync_tx_config_bank

// *** design/radio_cfg_defs.svh ***
`ifndef RADIO_CFG_DEFS_SVH
`define RADIO_CFG_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_REF_DIV      8'h13
`define IDX_RSSI         8'h14
`define IDX_ONOFF        8'h15
`define IDX_PAT3         8'h16
`define IDX_PAT2         8'h17
`define IDX_PAT1         8'h18
`define IDX_PAT0         8'h19
`define IDX_TXFP         8'h1a
`define IDX_PAT_CTRL     8'h12
`define IDX_PAT_STAT     8'h20

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_REF_DIV      8'h07
`define RST_ONOFF        8'h00
`define RST_PAT          8'h00
`define RST_TXFP         8'h70
`define RST_PAT_CTRL     8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_STEP_LSB       5
`define F_LEN_LSB        2
`define F_COEF_LSB       0
`define F_CUT_LSB        4
`define F_POUT_LSB       1
`define F_RECOG_BIT      5
`define F_SIZE_LSB       3
`define F_TOL_LSB        1
`define POUT_MAX_CODE    3'h5

`endif

// *** design/radio_cfg_pkg.sv ***
package radio_cfg_pkg;

  typedef struct packed {
    logic [2:0] peak_level_reduction;
    logic [2:0] peak_update_period;
    logic [1:0] average_filter_coeff_select;
  } onoff_cfg_t;

  typedef struct packed {
    logic [3:0] tx_antialias_cutoff;
    logic [2:0] tx_power;
    logic       unused;
  } tx_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01
  } tx_state_t;

endpackage : radio_cfg_pkg

// *** test/cfg_bank_props.sv ***
module cfg_bank_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        ref_clk_tick,
  input wire logic        rx_bit_valid,
  input wire logic        pattern_found,
  input wire logic [2:0]  peak_level_reduction,
  input wire logic [1:0]  average_filter_coeff_select,
  input wire logic [3:0]  tx_antialias_cutoff,
  input wire logic [2:0]  tx_power
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       wr;
  logic       ok_q;
  logic [7:0] div_q;
  logic [7:0] gap_q;
  assign wr = psel && penable && pwrite;
  // ---------------------------------------------
  // Helper
  // ---------------------------------------------
  // Gap trusted only after a tick with no divider write since
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h07;
      gap_q <= 8'h00;
      ok_q  <= 1'b0;
    end else begin
      gap_q <= ref_clk_tick ? 8'h00 : gap_q + 8'h01;
      ok_q  <= (ok_q || ref_clk_tick) && !(wr && paddr == 12'h04c);
      if (wr && paddr == 12'h04c) div_q <= pwdata[7:0];
    end
  end
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  AST_TICK_GAP: assert property (ref_clk_tick && ok_q |-> gap_q == div_q)
    else $error("tick gap wrong");
  // Field register takes the write, the output follows one cycle later
  AST_STEP: assert property (wr && paddr == 12'h054 |=> ##1
    peak_level_reduction == $past(pwdata[7:5], 2)) else $error("step not applied");
  AST_COEF: assert property (wr && paddr == 12'h054 |=> ##1
    average_filter_coeff_select == $past(pwdata[1:0], 2)) else $error("coef not applied");
  AST_CUT: assert property (wr && paddr == 12'h068 |=> ##1
    tx_antialias_cutoff == $past(pwdata[7:4], 2)) else $error("cutoff not applied");
  AST_PWR: assert property (wr && paddr == 12'h068 && pwdata[3:1] <= 3'h5 |=> ##1
    tx_power == $past(pwdata[3:1], 2)) else $error("power not applied");
  AST_PWR_MAX: assert property (tx_power <= 3'h5)
    else $error("power code unused");
  AST_RO_ERR: assert property (psel && penable && paddr inside {12'h050, 12'h0c0} |->
    pslverr == (paddr == 12'h0c0)) else $error("slave error wrong");
  AST_FOUND: assert property (pattern_found |-> $past(rx_bit_valid))
    else $error("found without bit");
  cover property (ref_clk_tick && ok_q);
  cover property (pattern_found);
  cover property (wr && paddr == 12'h068);
endmodule : cfg_bank_props

// *** test/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, tx_start, rx_bit, rx_bit_valid, ev;
  logic        pready, pslverr, tx_bit, tx_bit_valid, tx_busy, pattern_found;
  logic        ref_clk_tick, peak_update, b, x;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, rdv, pat, w;
  logic [7:0]  rssi_in;
  logic [2:0]  peak_level_reduction, tx_power;
  logic [1:0]  average_filter_coeff_select;
  logic [3:0]  tx_antialias_cutoff;
  logic [7:0]  m [int];
  logic        q [$];
  int          error_cnt, comparisons, p;

  localparam int CHIP_CYCLES = 16;

  radio_rx_sync_tx_config_bank #(
    .CHIP_DIV (CHIP_CYCLES)
  ) dut (
    .pclk                        (pclk),
    .presetn                     (presetn),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .prdata                      (prdata),
    .pready                      (pready),
    .pslverr                     (pslverr),
    .rssi_in                     (rssi_in),
    .tx_start                    (tx_start),
    .tx_bit                      (tx_bit),
    .tx_bit_valid                (tx_bit_valid),
    .tx_busy                     (tx_busy),
    .rx_bit                      (rx_bit),
    .rx_bit_valid                (rx_bit_valid),
    .pattern_found               (pattern_found),
    .ref_clk_tick                (ref_clk_tick),
    .peak_update                 (peak_update),
    .peak_level_reduction        (peak_level_reduction),
    .average_filter_coeff_select (average_filter_coeff_select),
    .tx_antialias_cutoff         (tx_antialias_cutoff),
    .tx_power                    (tx_power)
  );

  always #2 pclk = ~pclk;
  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task automatic reset_model();
    for (int i = 8'h12; i <= 8'h1a; i++) begin
      if (i != 8'h14) m[i] = i == 8'h13 ? 8'h07 : i == 8'h1a ? 8'h70 : 8'h00;
    end
    m[8'h20] = 8'h00;
  endtask : reset_model
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    ev  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask : apb
  task automatic wreg(input logic [7:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    if (i != 8'h14) m[i] = d[7:0] & (i == 8'h12 ? 8'h3e : i == 8'h1a ? 8'hfe : 8'hff);
  endtask : wreg
  task automatic rd(input logic [7:0] i);
    apb(1'b0, i, 32'h0);
    chk("register", rdv, {24'h0, m[i]});
  endtask : rd
  task automatic outs();
    // Outputs trail their field register by one cycle
    @(posedge pclk);
    chk("step", peak_level_reduction, m[8'h15][7:5]);
    chk("coef", average_filter_coeff_select, m[8'h15][1:0]);
    chk("cutoff", tx_antialias_cutoff, m[8'h1a][7:4]);
    chk("power", tx_power, m[8'h1a][3:1] > 3'h5 ? 3'h5 : m[8'h1a][3:1]);
  endtask : outs
  task automatic period(input logic pk, output int n);
    n = 0;
    while ((pk ? peak_update : ref_clk_tick) !== 1'b1 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((pk ? peak_update : ref_clk_tick) !== 1'b1 && n < 500);
  endtask : period
  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, tx_start, rx_bit, rx_bit_valid} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    rssi_in = 8'h00;
    seed = 32'hd7977009;
    w = 32'h0;
    m[8'h14] = 8'h00;
    reset_model();
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 8'h12; i <= 8'h1a; i++) rd(i[7:0]);
    outs();
    repeat (4) begin
      m[8'h14] = rnd();
      rssi_in <= m[8'h14];
      for (int i = 8'h12; i <= 8'h1a; i++) wreg(i[7:0], {24'h0, rnd()});
      for (int i = 8'h12; i <= 8'h1a; i++) rd(i[7:0]);
      outs();
    end
    wreg(8'h1a, 32'h0000000e);
    outs();
    apb(1'b1, 8'h30, 32'h000000ff);
    chk("slverr", ev, 1'b1);
    for (int d = 0; d < 5; d += 3) begin
      wreg(8'h13, d);
      period(1'b0, p);
      chk("tick", p, d + 1);
    end
    // Divider at zero: one chip lasts CHIP_CYCLES clock cycles
    wreg(8'h13, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wreg(8'h15, (c << 2) | (m[8'h15] & 8'he3));
      period(1'b1, p);
      period(1'b1, p);
      chk("peak", p, c < 4 ? CHIP_CYCLES << c : CHIP_CYCLES >> (c - 3));
    end
    for (int s = 0; s < 4; s++) begin
      wreg(8'h12, s << 3);
      pat = {m[8'h16], m[8'h17], m[8'h18], m[8'h19]};
      tx_start <= 1'b1;
      @(posedge pclk);
      tx_start <= 1'b0;
      @(posedge pclk);
      chk("tx_busy", tx_busy, 1'b1);
      q = {};
      repeat (100) begin
        @(posedge pclk);
        if (tx_bit_valid === 1'b1) q.push_back(tx_bit);
      end
      chk("tx_idle", tx_busy, 1'b0);
      chk("tx_count", q.size(), 8 * (s + 1));
      foreach (q[k]) chk("tx_bit", q[k], pat[31 - k]);
    end
    // Inverted lead-in; the model window follows every shifted bit
    for (int t = 0; t < 4; t++) begin
      for (int e = t; e < t + 2; e++) begin
        wreg(8'h12, 8'h38 | (t << 1));
        for (int k = 63; k >= 0; k--) begin
          b = k > 31 ? ~pat[k - 32] : pat[k] ^ (k < e);
          w = {w[30:0], b};
          x = $countones(w ^ pat) <= t;
          m[8'h20] = m[8'h20] | {7'h00, x};
          rx_bit       <= b;
          rx_bit_valid <= 1'b1;
          @(posedge pclk);
          rx_bit_valid <= 1'b0;
          @(posedge pclk);
          ev = pattern_found;
          chk("found_bit", pattern_found, x);
        end
        chk("found", ev, e <= t);
        rd(8'h20);
        apb(1'b1, 8'h20, 32'h00000001);
        m[8'h20] = 8'h00;
        rd(8'h20);
      end
    end
    // Mid-run reset returns every register but RSSI to its reset value; RSSI reads the pin again
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_model();
    @(posedge pclk);
    for (int i = 8'h12; i <= 8'h1a; i++) rd(i[7:0]);
    rd(8'h20);
    outs();
    print_verdict();
  end
endmodule : tb_top

bind radio_rx_sync_tx_config_bank cfg_bank_props chk_i (
  .pclk                        (pclk),
  .presetn                     (presetn),
  .psel                        (psel),
  .penable                     (penable),
  .pwrite                      (pwrite),
  .paddr                       (paddr),
  .pwdata                      (pwdata),
  .pslverr                     (pslverr),
  .ref_clk_tick                (ref_clk_tick),
  .rx_bit_valid                (rx_bit_valid),
  .pattern_found               (pattern_found),
  .peak_level_reduction        (peak_level_reduction),
  .average_filter_coeff_select (average_filter_coeff_select),
  .tx_antialias_cutoff         (tx_antialias_cutoff),
  .tx_power                    (tx_power)
);
